//--- inc/ddrc_pkg.sv
// Constants, pin layout, command and power state types for the DDR3
// command pin block.
// Assumes pins arrive as one packed vector laid out as below.
package ddrc_pkg;
   // ****************************************
   // Geometry
   // ****************************************
   localparam int BANKS = 8;
   localparam int BA_W = 3;
   localparam int ADDR_W = 14;
   localparam int COL_W = 10;
   localparam int DQ_W = 8;
   localparam int MR_CNT = 4;
   localparam int MR_SEL_W = 2;
   localparam logic [3:0] BURST_FULL = 4'h8;
   localparam logic [3:0] BURST_CHOP = 4'h4;

   // ****************************************
   // Address and mode register bit positions
   // ****************************************
   localparam int A_AP = 10;
   localparam int A_BC = 12;
   localparam int MR1_TDQS = 11;
   localparam int MR0_BL_LSB = 0;
   localparam logic [1:0] BL_FIX8 = 2'h0;
   localparam logic [1:0] BL_OTF = 2'h1;
   localparam logic [1:0] BL_FIX4 = 2'h2;
   localparam int MR1_RTT0 = 2;
   localparam int MR1_RTT1 = 6;
   localparam int MR1_RTT2 = 9;
   localparam int MR2_RTTW0 = 9;
   localparam int MR2_RTTW1 = 10;
   localparam int MR_IDX0 = 0;
   localparam int MR_IDX1 = 1;
   localparam int MR_IDX2 = 2;

   // ****************************************
   // Pin vector layout
   // ****************************************
   localparam int P_DQ = 0;
   localparam int P_DQSN = 8;
   localparam int P_DQS = 9;
   localparam int P_DM = 10;
   localparam int P_ODT = 11;
   localparam int P_ADDR = 12;
   localparam int P_BA = 26;
   localparam int P_WEN = 29;
   localparam int P_CASN = 30;
   localparam int P_RASN = 31;
   localparam int P_CSN = 32;
   localparam int P_CKE = 33;
   localparam int P_CKN = 34;
   localparam int P_CK = 35;
   localparam int PIN_W = 36;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [3:0] {
      CMD_DESEL, CMD_NOP, CMD_MRS, CMD_REF, CMD_PRE,
      CMD_ACT, CMD_WR, CMD_RD, CMD_ZQ
   } ddrc_cmd_e;

   typedef enum logic [1:0] {
      PW_RUN, PW_PRE_PD, PW_ACT_PD, PW_SREF
   } ddrc_pwr_e;

   // Select plus RAS, CAS, WE, all active low
   function automatic ddrc_cmd_e ddrc_decode(input logic [3:0] c);
      ddrc_cmd_e r;
      r = CMD_NOP;
      if (c[3]) begin
         r = CMD_DESEL;
      end else begin
         case (c[2:0])
            3'h0: r = CMD_MRS;
            3'h1: r = CMD_REF;
            3'h2: r = CMD_PRE;
            3'h3: r = CMD_ACT;
            3'h4: r = CMD_WR;
            3'h5: r = CMD_RD;
            3'h6: r = CMD_ZQ;
            default: r = CMD_NOP;
         endcase
      end
      return r;
   endfunction : ddrc_decode
endpackage : ddrc_pkg

//--- logic/ddrc_burst_beat.sv
// Beat counter for one read or write burst of eight or four beats.
// Assumes start and beat pulses come from logic on mclk.
module ddrc_burst_beat (
   input wire logic mclk, // Clock
   input wire logic rst, // Sync reset
   input wire logic resetN, // Async reset
   input wire logic start, // Open a burst
   input wire logic chop, // Four beats instead of eight
   input wire logic beat, // One beat passed
   output logic busy, // Burst in progress
   output logic last, // Final beat this cycle
   output logic [2:0] beatIdx // Current beat number
);
   typedef struct packed {
      logic busy;
      logic chop;
      logic [2:0] idx;
   } ddrc_beat_s;

   ddrc_beat_s s_q, s_d;
   logic [3:0] lenM1;

   // ****************************************
   // Counter
   // ****************************************
   always_comb begin
      s_d = s_q;
      lenM1 = (s_q.chop ? ddrc_pkg::BURST_CHOP : ddrc_pkg::BURST_FULL)
              - 4'h1;
      last = s_q.busy && beat && ({1'b0, s_q.idx} == lenM1);
      if (s_q.busy && beat) begin
         s_d.idx = s_q.idx + 3'h1;
      end
      if (last) begin
         s_d.busy = 1'b0;
      end
      if (start) begin
         s_d.busy = 1'b1;
         s_d.chop = chop;
         s_d.idx = 3'h0;
      end
      if (rst) begin
         s_d = '0;
      end
   end

   always_ff @(posedge mclk or negedge resetN) begin
      if (!resetN) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign busy = s_q.busy;
   assign beatIdx = s_q.idx;

   // ****************************************
   // Checks
   // ****************************************
   a_burst_length: assert property (@(posedge mclk) disable iff (rst || !resetN)
      last |-> (beatIdx == (s_q.chop ? 3'h3 : 3'h7)))
      else $error("burst ended at wrong beat");
   a_burst_start: assert property (@(posedge mclk) disable iff (rst || !resetN)
      start |=> busy && beatIdx == 3'h0)
      else $error("burst did not open");
endmodule : ddrc_burst_beat

//--- logic/ddrc_cmd_pins.sv
// Command, address and control pin logic of an eight bank DDR3 device.
// Assumes all pins are asynchronous to mclk, which runs much faster than
// the pin clock, and a controller that keeps its own obligations.
// Contract
// - sample inputs on CK rise, CK# fall
// - clocks, command buffers and output drivers run only with CKE high
// - CKE low picks precharge, active or self refresh
// - self refresh exit needs no clock edge
// - power down gates buffers except clock, termination, CKE
// - select high masks the command
// - command from select, RAS, CAS, WE
// - termination enable drives data, strobe, mask termination
// - termination ignored in self refresh or disabled
// - masked write beats are discarded
// - shared pin is mask or termination strobe
// - bank bits pick bank or mode register
// - address carries row, column or opcode
// - bit 10 requests auto precharge on access
// - bit 10 precharges one or all banks
// - bit 12 low chops the burst
// - reset is active low and asynchronous
// - reset discards all stored state
// - bursts are eight beats or four chopped
// - chop by bit 12 only when enabled
module ddrc_cmd_pins (
   input wire logic mclk, // Clock 50 MHz
   input wire logic rst, // Sync reset, high
   input wire logic resetN, // Device reset pin, low
   input wire logic ck, // Pin clock true
   input wire logic ckN, // Pin clock complement
   input wire logic cke, // Clock enable pin
   input wire logic csN, // Chip select pin
   input wire logic rasN, // Row strobe pin
   input wire logic casN, // Column strobe pin
   input wire logic weN, // Write enable pin
   input wire logic [2:0] ba, // Bank address pins
   input wire logic [13:0] addr, // Address pins
   input wire logic odt, // Termination enable pin
   input wire logic dm, // Data mask pin
   input wire logic dqs, // Data strobe true
   input wire logic dqsN, // Data strobe complement
   input wire logic [7:0] dq, // Data pins, input side
   output logic cmdValid, // Command taken, pulse
   output ddrc_pkg::ddrc_cmd_e cmdCode, // Command taken
   output logic [2:0] cmdBank, // Bank of command
   output logic [13:0] cmdAddr, // Address of command
   output logic wrValid, // Kept write beat, pulse
   output logic [7:0] wrData, // Write beat data
   output logic [2:0] wrBank, // Write beat bank
   output logic [9:0] wrCol, // Write beat column
   output logic rdValid, // Read beat slot, pulse
   output logic [7:0] openBanks, // Banks with a row open
   output ddrc_pkg::ddrc_pwr_e pwrState, // Power state
   output logic clkRun, // Internal clocks running
   output logic outDrvEn, // Output drivers enabled
   output logic cmdBufEn, // Command and address buffers
   output logic odtBufEn, // Termination enable buffer
   output logic ckBufEn, // Clock pair buffers
   output logic ckeBufEn, // Clock enable buffer
   output logic termDq, // Termination on DQ, DQS, mask pin
   output logic termTdqsN, // Termination on second strobe
   output logic maskMode, // Shared pin acts as mask
   output logic contentsValid // Low until first write after reset
);
   typedef struct packed {
      logic [ddrc_pkg::PIN_W-1:0] pin1;
      logic [ddrc_pkg::PIN_W-1:0] pin2;
      logic [ddrc_pkg::PIN_W-1:0] pinP;
      ddrc_pkg::ddrc_pwr_e pwr;
      logic [ddrc_pkg::BANKS-1:0] open;
      logic [ddrc_pkg::BANKS-1:0][ddrc_pkg::ADDR_W-1:0] row;
      logic [ddrc_pkg::MR_CNT-1:0][ddrc_pkg::ADDR_W-1:0] mr;
      logic wrBurst;
      logic rdBurst;
      logic [2:0] bBank;
      logic bAp;
      logic [9:0] bCol;
      logic cmdValid;
      ddrc_pkg::ddrc_cmd_e cmdCode;
      logic [2:0] cmdBank;
      logic [13:0] cmdAddr;
      logic wrValid;
      logic [7:0] wrData;
      logic [2:0] wrBank;
      logic [9:0] wrCol;
      logic rdValid;
      logic odtOn;
      logic kept;
   } ddrc_state_s;

   // Every field starts at zero: banks closed, mode registers cleared
   localparam ddrc_state_s ST_RST = '0;

   ddrc_state_s s_q, s_d;
   logic [ddrc_pkg::PIN_W-1:0] pins, p, pp;
   logic ckEdge, ckAny, dqsEdge, keS, beat, last, busy, chop, start;
   logic odtAllowed, dmEn;
   logic [2:0] baS, beatIdx;
   logic [13:0] adS;
   logic [13:0] mr0, mr1, mr2;
   ddrc_pkg::ddrc_cmd_e cmd;

   assign pins = {ck, ckN, cke, csN, rasN, casN, weN, ba, addr,
                  odt, dm, dqs, dqsN, dq};

   // ****************************************
   // Burst chop selection
   // ****************************************
   function automatic logic ddrc_chop(input logic [1:0] bl,
                                      input logic a12);
      logic r;
      r = 1'b0;
      case (bl)
         ddrc_pkg::BL_OTF: r = !a12;
         ddrc_pkg::BL_FIX4: r = 1'b1;
         default: r = 1'b0;
      endcase
      return r;
   endfunction : ddrc_chop

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      s_d = s_q;
      // Two stage synchroniser, third stage only for edge detection
      s_d.pin1 = pins;
      s_d.pin2 = s_q.pin1;
      s_d.pinP = s_q.pin2;
      p = s_q.pin2;
      pp = s_q.pinP;
      s_d.cmdValid = 1'b0;
      s_d.wrValid = 1'b0;
      s_d.rdValid = 1'b0;
      start = 1'b0;
      chop = 1'b0;
      mr0 = s_q.mr[ddrc_pkg::MR_IDX0];
      mr1 = s_q.mr[ddrc_pkg::MR_IDX1];
      mr2 = s_q.mr[ddrc_pkg::MR_IDX2];
      // Both edges seen together; a skewed pair waits for the next one
      ckEdge = p[ddrc_pkg::P_CK] && !pp[ddrc_pkg::P_CK]
               && !p[ddrc_pkg::P_CKN] && pp[ddrc_pkg::P_CKN];
      ckAny = p[ddrc_pkg::P_CK] != pp[ddrc_pkg::P_CK];
      dqsEdge = (p[ddrc_pkg::P_DQS] != pp[ddrc_pkg::P_DQS])
                && (p[ddrc_pkg::P_DQS] != p[ddrc_pkg::P_DQSN]);
      keS = p[ddrc_pkg::P_CKE];
      baS = p[ddrc_pkg::P_BA +: ddrc_pkg::BA_W];
      adS = p[ddrc_pkg::P_ADDR +: ddrc_pkg::ADDR_W];
      cmd = ddrc_pkg::ddrc_decode({p[ddrc_pkg::P_CSN],
                                   p[ddrc_pkg::P_RASN],
                                   p[ddrc_pkg::P_CASN],
                                   p[ddrc_pkg::P_WEN]});
      dmEn = !mr1[ddrc_pkg::MR1_TDQS];
      odtAllowed = mr1[ddrc_pkg::MR1_RTT0] || mr1[ddrc_pkg::MR1_RTT1]
                   || mr1[ddrc_pkg::MR1_RTT2] || mr2[ddrc_pkg::MR2_RTTW0]
                   || mr2[ddrc_pkg::MR2_RTTW1];

      // Beats advance on strobe edges for writes, clock edges for reads
      beat = (s_q.wrBurst && dqsEdge) || (s_q.rdBurst && ckAny);
      if (s_q.wrBurst && dqsEdge && !(dmEn && p[ddrc_pkg::P_DM])) begin
         s_d.wrValid = 1'b1;
         s_d.wrData = p[ddrc_pkg::P_DQ +: ddrc_pkg::DQ_W];
         s_d.wrBank = s_q.bBank;
         s_d.wrCol = s_q.bCol + {7'h00, beatIdx};
         s_d.kept = 1'b1;
      end
      if (s_q.rdBurst && ckAny) begin
         s_d.rdValid = 1'b1;
      end
      if (last) begin
         s_d.wrBurst = 1'b0;
         s_d.rdBurst = 1'b0;
         if (s_q.bAp) begin
            s_d.open[s_q.bBank] = 1'b0;
         end
      end

      case (s_q.pwr)
         ddrc_pkg::PW_RUN: begin
            if (ckEdge && !keS) begin
               if (cmd == ddrc_pkg::CMD_REF && s_q.open == '0) begin
                  s_d.pwr = ddrc_pkg::PW_SREF;
               end else if (s_q.open == '0) begin
                  s_d.pwr = ddrc_pkg::PW_PRE_PD;
               end else begin
                  s_d.pwr = ddrc_pkg::PW_ACT_PD;
               end
            end else if (ckEdge && cmd != ddrc_pkg::CMD_DESEL) begin
               s_d.cmdValid = 1'b1;
               s_d.cmdCode = cmd;
               s_d.cmdBank = baS;
               s_d.cmdAddr = adS;
               case (cmd)
                  ddrc_pkg::CMD_MRS: begin
                     s_d.mr[baS[ddrc_pkg::MR_SEL_W-1:0]] = adS;
                  end
                  ddrc_pkg::CMD_ACT: begin
                     s_d.open[baS] = 1'b1;
                     s_d.row[baS] = adS;
                  end
                  ddrc_pkg::CMD_PRE: begin
                     if (adS[ddrc_pkg::A_AP]) begin
                        s_d.open = '0;
                     end else begin
                        s_d.open[baS] = 1'b0;
                     end
                  end
                  ddrc_pkg::CMD_WR, ddrc_pkg::CMD_RD: begin
                     // A closed bank or a busy burst drops the access
                     if (s_q.open[baS] && !busy) begin
                        start = 1'b1;
                        chop = ddrc_chop(mr0[ddrc_pkg::MR0_BL_LSB +: 2],
                                         adS[ddrc_pkg::A_BC]);
                        s_d.wrBurst = cmd == ddrc_pkg::CMD_WR;
                        s_d.rdBurst = cmd == ddrc_pkg::CMD_RD;
                        s_d.bBank = baS;
                        s_d.bAp = adS[ddrc_pkg::A_AP];
                        s_d.bCol = adS[ddrc_pkg::COL_W-1:0];
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
         ddrc_pkg::PW_PRE_PD, ddrc_pkg::PW_ACT_PD: begin
            if (ckEdge && keS) begin
               s_d.pwr = ddrc_pkg::PW_RUN;
            end
         end
         ddrc_pkg::PW_SREF: begin
            if (keS) begin
               s_d.pwr = ddrc_pkg::PW_RUN;
            end
         end
         default: s_d.pwr = ddrc_pkg::PW_RUN;
      endcase

      // Termination sampled on the clock, forced off when not usable
      if (ckEdge) begin
         s_d.odtOn = p[ddrc_pkg::P_ODT];
      end
      if (s_q.pwr == ddrc_pkg::PW_SREF || !odtAllowed) begin
         s_d.odtOn = 1'b0;
      end
      if (rst) begin
         s_d = ST_RST;
      end
   end

   // Pin reset clears everything, stored data is not trusted after it
   always_ff @(posedge mclk or negedge resetN) begin
      if (!resetN) begin
         s_q <= ST_RST;
      end else begin
         s_q <= s_d;
      end
   end

   ddrc_burst_beat u_beat (
      .mclk(mclk),
      .rst(rst),
      .resetN(resetN),
      .start(start),
      .chop(chop),
      .beat(beat),
      .busy(busy),
      .last(last),
      .beatIdx(beatIdx)
   );

   // ****************************************
   // Outputs
   // ****************************************
   assign cmdValid = s_q.cmdValid;
   assign cmdCode = s_q.cmdCode;
   assign cmdBank = s_q.cmdBank;
   assign cmdAddr = s_q.cmdAddr;
   assign wrValid = s_q.wrValid;
   assign wrData = s_q.wrData;
   assign wrBank = s_q.wrBank;
   assign wrCol = s_q.wrCol;
   assign rdValid = s_q.rdValid;
   assign openBanks = s_q.open;
   assign pwrState = s_q.pwr;
   assign clkRun = s_q.pwr == ddrc_pkg::PW_RUN;
   assign outDrvEn = s_q.pwr == ddrc_pkg::PW_RUN;
   assign cmdBufEn = s_q.pwr == ddrc_pkg::PW_RUN;
   assign odtBufEn = s_q.pwr != ddrc_pkg::PW_SREF;
   assign ckBufEn = s_q.pwr != ddrc_pkg::PW_SREF;
   assign ckeBufEn = 1'b1;
   assign termDq = s_q.odtOn;
   assign termTdqsN = s_q.odtOn && !dmEn;
   assign maskMode = dmEn;
   assign contentsValid = s_q.kept;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst || !resetN);

   a_select_masks: assert property (
      ckEdge && p[ddrc_pkg::P_CSN] |=> !cmdValid)
      else $error("command taken with select high");
   a_cmd_on_edge: assert property (
      cmdValid |-> $past(ckEdge) && $past(keS))
      else $error("command without clock edge");
   a_active_pd: assert property (
      s_q.pwr == ddrc_pkg::PW_RUN && ckEdge && !keS && s_q.open != '0
      |=> pwrState == ddrc_pkg::PW_ACT_PD && !clkRun)
      else $error("active power down not entered");
   a_precharge_pd: assert property (
      s_q.pwr == ddrc_pkg::PW_RUN && ckEdge && !keS && s_q.open == '0
      && cmd != ddrc_pkg::CMD_REF |=> pwrState == ddrc_pkg::PW_PRE_PD)
      else $error("precharge power down not entered");
   a_sref_exit: assert property (
      s_q.pwr == ddrc_pkg::PW_SREF && keS |=> pwrState == ddrc_pkg::PW_RUN)
      else $error("self refresh exit missed");
   a_sref_odt: assert property (
      s_q.pwr == ddrc_pkg::PW_SREF ##1 s_q.pwr == ddrc_pkg::PW_SREF
      |-> !termDq && !odtBufEn)
      else $error("termination active in self refresh");
   a_mask_drop: assert property (
      s_q.wrBurst && dqsEdge && dmEn && p[ddrc_pkg::P_DM] |=> !wrValid)
      else $error("masked beat kept");
   a_pre_all: assert property (
      cmdValid && cmdCode == ddrc_pkg::CMD_PRE && cmdAddr[ddrc_pkg::A_AP]
      |-> openBanks == '0)
      else $error("precharge all left a bank open");
   a_act_opens: assert property (
      cmdValid && cmdCode == ddrc_pkg::CMD_ACT |-> openBanks[cmdBank]
      && s_q.row[cmdBank] == cmdAddr)
      else $error("activate did not open row");
   a_auto_pre: assert property (
      last && s_q.bAp && !start |=> !openBanks[$past(s_q.bBank)])
      else $error("auto precharge missed");

   c_sref: cover property (s_q.pwr == ddrc_pkg::PW_SREF ##[1:50]
      s_q.pwr == ddrc_pkg::PW_RUN);
   c_act_pd: cover property (s_q.pwr == ddrc_pkg::PW_ACT_PD);
   c_chop_wr: cover property (start && chop && s_d.wrBurst);
   c_masked: cover property (s_q.wrBurst && dqsEdge && p[ddrc_pkg::P_DM]);
endmodule : ddrc_cmd_pins

//--- verif/ddrc_ctl_model.sv
// Controller model that drives the DDR3 command, strobe and data pins.
// Assumes mclk is the bench clock; pins change only on its falling edge.
module ddrc_ctl_model (
   input wire logic mclk, // Bench clock
   output logic resetN, // Device reset
   output logic ck, // Pin clock true
   output logic ckN, // Pin clock complement
   output logic cke, // Clock enable
   output logic csN, // Chip select
   output logic rasN, // Row strobe
   output logic casN, // Column strobe
   output logic weN, // Write enable
   output logic [2:0] ba, // Bank address
   output logic [13:0] addr, // Address
   output logic odt, // Termination enable
   output logic dm, // Data mask
   output logic dqs, // Strobe true
   output logic dqsN, // Strobe complement
   output logic [7:0] dq // Write data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {resetN, cke, csN, rasN, casN, weN} = 6'h3f;
      {ck, ckN, dqs, dqsN, odt, dm} = 6'h14;
      ba = 3'h0;
      addr = 14'h0;
      dq = 8'h0;
   end
   task automatic waitN(input int n);
      repeat (n) @(negedge mclk);
   endtask : waitN
   // Pins held 4 cycles either side of the rise, beyond the 3 required
   task automatic cmd(input logic [3:0] c, input logic [2:0] b,
      input logic [13:0] a, input logic k);
      {csN, rasN, casN, weN} = c;
      ba = b;
      addr = a;
      cke = k;
      waitN(4);
      {ck, ckN} = 2'h2;
      waitN(4);
      {ck, ckN} = 2'h1;
      csN = 1'b1;
      // Released lines show the inverse, never a stale value
      ba = ~ba;
      addr = ~addr;
   endtask : cmd
   task automatic clocks(input int n);
      repeat (n) begin
         waitN(4);
         {ck, ckN} = ~{ck, ckN};
      end
   endtask : clocks
   // Clock enable stays high for the whole burst
   task automatic beats(input int n, input int m);
      for (int i = 0; i < n; i++) begin
         dq = 8'h30 + 8'(i);
         dm = (i == m);
         waitN(2);
         dqs = ~dqs;
         dqsN = ~dqsN;
         waitN(4);
      end
      dq = ~dq;
      dm = ~dm;
   endtask : beats
endmodule : ddrc_ctl_model

//--- verif/testbench.sv
// Self-checking bench for the DDR3 command pin block.
// Assumes the controller model drives every pin input.
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   wire logic resetN, ck, ckN, cke, csN, rasN, casN, weN, odt, dm, dqs, dqsN;
   wire logic [2:0] ba;
   wire logic [13:0] addr;
   wire logic [7:0] dq;
   logic cmdValid, wrValid, rdValid, clkRun, outDrvEn, cmdBufEn, odtBufEn;
   logic ckBufEn, ckeBufEn, termDq, termTdqsN, maskMode, contentsValid;
   ddrc_pkg::ddrc_cmd_e cmdCode;
   ddrc_pkg::ddrc_pwr_e pwrState;
   logic [2:0] cmdBank, wrBank;
   logic [13:0] cmdAddr;
   logic [7:0] wrData, openBanks;
   logic [9:0] wrCol;
   int fails = 0;
   int tests_run = 0;
   int nCmd = 0, nWr = 0, nRd = 0, c0, w0, r0, cycles = 0;
   ddrc_pkg::ddrc_cmd_e codes [8] = '{ddrc_pkg::CMD_MRS, ddrc_pkg::CMD_REF,
      ddrc_pkg::CMD_PRE, ddrc_pkg::CMD_ACT, ddrc_pkg::CMD_WR,
      ddrc_pkg::CMD_RD, ddrc_pkg::CMD_ZQ, ddrc_pkg::CMD_NOP};

   ddrc_ctl_model m (.mclk, .resetN, .ck, .ckN, .cke, .csN, .rasN, .casN,
      .weN, .ba, .addr, .odt, .dm, .dqs, .dqsN, .dq);
   ddrc_cmd_pins uut (.mclk, .rst, .resetN, .ck, .ckN, .cke, .csN, .rasN,
      .casN, .weN, .ba, .addr, .odt, .dm, .dqs, .dqsN, .dq, .cmdValid,
      .cmdCode, .cmdBank, .cmdAddr, .wrValid, .wrData, .wrBank, .wrCol,
      .rdValid, .openBanks, .pwrState, .clkRun, .outDrvEn, .cmdBufEn,
      .odtBufEn, .ckBufEn, .ckeBufEn, .termDq, .termTdqsN, .maskMode,
      .contentsValid);

   always #10 mclk = ~mclk;
   // Pulses stand a whole cycle, so count them away from the launching edge
   always @(negedge mclk) begin
      cycles++;
      if (cmdValid === 1'b1) nCmd++;
      if (wrValid === 1'b1) nWr++;
      if (rdValid === 1'b1) nRd++;
      if (cycles == 20000) begin
         fails++;
         conclude();
      end
   end

   task automatic conclude;
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic settle;
      repeat (6) @(negedge mclk);
      c0 = nCmd;
      w0 = nWr;
      r0 = nRd;
   endtask : settle
   task automatic cnt(input logic [15:0] c, w, r);
      repeat (6) @(negedge mclk);
      chk("commands", c, 16'(nCmd - c0));
      chk("write beats", w, 16'(nWr - w0));
      chk("read beats", r, 16'(nRd - r0));
   endtask : cnt

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset;
      chk("power", 16'(ddrc_pkg::PW_RUN), 16'(pwrState));
      chk("enables", 16'h3f, {clkRun, outDrvEn, cmdBufEn, odtBufEn,
         ckBufEn, ckeBufEn});
      chk("flags", 16'h4, {maskMode, contentsValid, termDq});
   endtask : t_reset
   task automatic t_codes;
      for (int i = 0; i < 8; i++) begin
         settle();
         // Own bank per code: access to a closed bank starts no burst
         m.cmd(4'(i), 3'(i), 14'h0, 1'b1);
         cnt(1, 0, 0);
         chk("code", 16'(codes[i]), 16'(cmdCode));
      end
   endtask : t_codes
   task automatic t_select;
      settle();
      m.cmd(4'hb, 3'h3, 14'h0123, 1'b1);
      cnt(0, 0, 0);
      settle();
      m.cmd(4'h3, 3'h3, 14'h2abc, 1'b1);
      cnt(1, 0, 0);
      chk("bank", 16'h3, 16'(cmdBank));
      chk("row", 16'h2abc, 16'(cmdAddr));
      chk("open", 16'h08, 16'(openBanks));
   endtask : t_select
   task automatic t_write;
      settle();
      m.cmd(4'h4, 3'h3, 14'h1410, 1'b1);
      m.beats(8, 2);
      cnt(1, 7, 0);
      chk("column", 16'h017, 16'(wrCol));
      chk("data", 16'h37, 16'(wrData));
      chk("wbank", 16'h3, 16'(wrBank));
      chk("open", 16'h0, 16'(openBanks));
      chk("contents", 16'h1, 16'(contentsValid));
   endtask : t_write
   task automatic t_chop;
      m.cmd(4'h0, 3'h0, 14'h0001, 1'b1);
      m.cmd(4'h3, 3'h1, 14'h0005, 1'b1);
      settle();
      m.cmd(4'h4, 3'h1, 14'h0020, 1'b1);
      m.beats(4, 9);
      cnt(1, 4, 0);
      chk("open", 16'h02, 16'(openBanks));
      settle();
      m.cmd(4'h5, 3'h1, 14'h0000, 1'b1);
      m.clocks(14);
      cnt(1, 0, 4);
      settle();
      m.cmd(4'h5, 3'h1, 14'h1000, 1'b1);
      m.clocks(22);
      cnt(1, 0, 8);
   endtask : t_chop
   task automatic t_pre;
      m.cmd(4'h3, 3'h0, 14'h0001, 1'b1);
      m.cmd(4'h3, 3'h2, 14'h0002, 1'b1);
      m.cmd(4'h2, 3'h2, 14'h0000, 1'b1);
      settle();
      chk("open", 16'h03, 16'(openBanks));
      m.cmd(4'h2, 3'h5, 14'h0400, 1'b1);
      settle();
      chk("open", 16'h00, 16'(openBanks));
   endtask : t_pre
   task automatic t_power;
      m.cmd(4'h3, 3'h5, 14'h0007, 1'b1);
      m.cmd(4'h7, 3'h0, 14'h0, 1'b0);
      settle();
      chk("power", 16'(ddrc_pkg::PW_ACT_PD), 16'(pwrState));
      chk("enables", 16'h07, {clkRun, outDrvEn, cmdBufEn, odtBufEn,
         ckBufEn, ckeBufEn});
      m.cmd(4'h3, 3'h6, 14'h0, 1'b0);
      cnt(0, 0, 0);
      m.cmd(4'hf, 3'h0, 14'h0, 1'b1);
      m.cmd(4'h2, 3'h0, 14'h0400, 1'b1);
      m.cmd(4'h7, 3'h0, 14'h0, 1'b0);
      settle();
      chk("power", 16'(ddrc_pkg::PW_PRE_PD), 16'(pwrState));
      m.cmd(4'hf, 3'h0, 14'h0, 1'b1);
      settle();
      chk("power", 16'(ddrc_pkg::PW_RUN), 16'(pwrState));
   endtask : t_power
   task automatic t_term;
      m.cmd(4'h0, 3'h1, 14'h0004, 1'b1);
      m.odt = 1'b1;
      m.cmd(4'h7, 3'h0, 14'h0, 1'b1);
      settle();
      chk("term", 16'h2, {termDq, termTdqsN});
      m.cmd(4'h0, 3'h1, 14'h0804, 1'b1);
      m.cmd(4'h7, 3'h0, 14'h0, 1'b1);
      settle();
      chk("term", 16'h3, {maskMode, termDq, termTdqsN});
      m.cmd(4'h1, 3'h0, 14'h0, 1'b0);
      settle();
      chk("power", 16'(ddrc_pkg::PW_SREF), 16'(pwrState));
      chk("bufs", 16'h1, {odtBufEn, ckBufEn, ckeBufEn});
      chk("term", 16'h0, {termDq, termTdqsN});
      // No clock edge: exit must come from the enable alone
      m.cke = 1'b1;
      settle();
      chk("power", 16'(ddrc_pkg::PW_RUN), 16'(pwrState));
      m.odt = 1'b0;
   endtask : t_term
   task automatic t_async;
      m.cmd(4'h3, 3'h4, 14'h0009, 1'b1);
      settle();
      m.resetN = 1'b0;
      @(negedge mclk);
      chk("wiped", 16'h2, {openBanks, maskMode, contentsValid});
      m.resetN = 1'b1;
      settle();
      chk("contents", 16'h0, 16'(contentsValid));
   endtask : t_async

   initial begin
      repeat (16) @(negedge mclk);
      rst = 1'b0;
      repeat (4) @(negedge mclk);
      t_reset();
      t_codes();
      t_select();
      t_write();
      t_chop();
      t_pre();
      t_power();
      t_term();
      t_async();
      conclude();
   end
endmodule : testbench
